/* File: rtl/ocx_clock_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - three gated clock enables from oscillator
// - peripheral clock feeds timers, card, converter, ports
// - control bit selects 6 or 12 periods
// - double speed affects cpu and peripheral
// - system reset leaves standard mode
// - standard mode divides oscillator by two
// - double speed runs at oscillator rate
// - speed bit value after pin reset from fuse
// - reset needs 64 high oscillator periods
// - reset pin wakes from idle, power-down
module ocx_clock_ctrl
  import ocx_pkg::*;
#(
  parameter int unsigned QUAL_PERIODS = RST_QUAL_PERIODS
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic rst_pin_i,
  input  wire logic boot_loader_select_pin_i,
  input  wire logic double_speed_default_fuse_i,
  input  wire logic double_speed_select_i,
  input  wire logic double_speed_wr_i,
  input  wire logic idle_req_i,
  input  wire logic pdown_req_i,
  output logic      pll_clk_en_o,
  output logic      cpu_clk_en_o,
  output logic      per_clk_en_o,
  output logic      timer0_clk_en_o,
  output logic      timer1_clk_en_o,
  output logic      card_clk_en_o,
  output logic      adc_clk_en_o,
  output logic      spi_clk_en_o,
  output logic      port_smp_clk_en_o,
  output logic      double_speed_o,
  output logic      core_rst_o,
  output logic      boot_loader_o
);

  logic     qual_rst;
  logic     qual_rst_d_reg;
  logic     fuse_s1_reg;
  logic     fuse_s2_reg;
  logic     boot_s1_reg;
  logic     boot_s2_reg;
  logic     pending_x2_reg;
  logic     phase_reg;
  logic     boot_reg;
  logic     tick;
  logic     cpu_en;
  logic     per_en;
  ocx_pwr_t pwr_reg;

  ocx_rst_qual #(
    .QUAL_PERIODS(QUAL_PERIODS)
  ) u_rst_qual (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .rst_pin_i  (rst_pin_i),
    .qual_rst_o (qual_rst)
  );

  // synchronisers run through reset so the pin level is real at release
  always_ff @(posedge core_clk_i) begin
    fuse_s1_reg <= double_speed_default_fuse_i;
    fuse_s2_reg <= fuse_s1_reg;
    boot_s1_reg <= boot_loader_select_pin_i;
    boot_s2_reg <= boot_s1_reg;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      qual_rst_d_reg <= 1'b1;
      core_rst_o     <= 1'b1;
    end else begin
      qual_rst_d_reg <= qual_rst;
      core_rst_o     <= qual_rst;
    end
  end

  // boot pin caught on the cycle the qualified reset falls
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      boot_reg <= 1'b0;
    end else if (qual_rst_d_reg && !qual_rst) begin
      boot_reg <= !boot_s2_reg;
    end
  end

  // requested speed; fuse gives the value at qualified pin reset release, system reset gives standard
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pending_x2_reg <= 1'b0;
    end else if (qual_rst) begin
      pending_x2_reg <= fuse_s2_reg;
    end else if (double_speed_wr_i) begin
      pending_x2_reg <= double_speed_select_i;
    end
  end

  // applied only at a machine-clock boundary so no period is cut
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      double_speed_o <= 1'b0;
    end else if (tick) begin
      double_speed_o <= pending_x2_reg;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      phase_reg <= DIV_PHASE_RST;
    end else if (double_speed_o) begin
      phase_reg <= DIV_PHASE_RST;
    end else begin
      phase_reg <= !phase_reg;
    end
  end

  // one tick each oscillator period in x2, every second otherwise
  assign tick = double_speed_o || phase_reg;

  // reset pin (qualified) always wakes the core
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || qual_rst) begin
      pwr_reg <= OCX_RUN;
    end else begin
      unique case (pwr_reg)
        OCX_RUN: begin
          if (pdown_req_i) begin
            pwr_reg <= OCX_DOWN;
          end else if (idle_req_i) begin
            pwr_reg <= OCX_IDLE;
          end
        end
        OCX_IDLE: begin
          if (pdown_req_i) begin
            pwr_reg <= OCX_DOWN;
          end
        end
        OCX_DOWN: begin
          pwr_reg <= OCX_DOWN;
        end
        default: begin
          pwr_reg <= OCX_RUN;
        end
      endcase
    end
  end

  assign cpu_en = tick && (pwr_reg == OCX_RUN);
  assign per_en = tick && (pwr_reg != OCX_DOWN);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pll_clk_en_o      <= 1'b0;
      cpu_clk_en_o      <= 1'b0;
      per_clk_en_o      <= 1'b0;
      timer0_clk_en_o   <= 1'b0;
      timer1_clk_en_o   <= 1'b0;
      card_clk_en_o     <= 1'b0;
      adc_clk_en_o      <= 1'b0;
      spi_clk_en_o      <= 1'b0;
      port_smp_clk_en_o <= 1'b0;
      boot_loader_o     <= 1'b0;
    end else begin
      pll_clk_en_o      <= (pwr_reg != OCX_DOWN);
      cpu_clk_en_o      <= cpu_en;
      per_clk_en_o      <= per_en;
      timer0_clk_en_o   <= per_en;
      timer1_clk_en_o   <= per_en;
      card_clk_en_o     <= per_en;
      adc_clk_en_o      <= per_en;
      spi_clk_en_o      <= per_en;
      port_smp_clk_en_o <= per_en;
      boot_loader_o     <= boot_reg;
    end
  end

  a_std_half_rate: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!double_speed_o && per_clk_en_o && $stable(double_speed_o)) |=> !per_clk_en_o)
    else $error("peripheral enable not halved in standard mode");

  a_x2_full_rate: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (double_speed_o && (pwr_reg == OCX_RUN)) |=> cpu_clk_en_o)
    else $error("cpu enable gap in double speed");

  a_mode_on_tick: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(double_speed_o) |-> $past(tick))
    else $error("speed changed off a tick");

  a_x2_both_clocks: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    cpu_clk_en_o |-> per_clk_en_o)
    else $error("cpu runs without peripheral");

  a_wake_on_reset: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    qual_rst |=> (pwr_reg == OCX_RUN))
    else $error("reset did not wake");

  a_std_after_reset: assert property (@(posedge core_clk_i)
    $fell(sys_rst_i) |-> !double_speed_o)
    else $error("not standard mode after reset");

  a_fuse_loaded: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(qual_rst) |-> (pending_x2_reg == $past(fuse_s2_reg)))
    else $error("fuse not loaded");

  a_boot_sample: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (qual_rst_d_reg && !qual_rst) |=> (boot_reg == !$past(boot_s2_reg)))
    else $error("boot pin sampled wrong");

  a_pll_gated: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (pwr_reg == OCX_DOWN) |=> !pll_clk_en_o && !cpu_clk_en_o)
    else $error("clocks running in power down");

endmodule : ocx_clock_ctrl
`default_nettype wire

/* File: rtl/ocx_pkg.sv */
package ocx_pkg;

  // rule 9: reset pin must be high this many oscillator periods
  localparam int unsigned RST_QUAL_PERIODS = 64;
  localparam int unsigned RST_CNT_W        = 7;

  // oscillator periods per machine cycle in each mode
  localparam int unsigned PERIODS_STD = 12;
  localparam int unsigned PERIODS_X2  = 6;

  // divider phase after reset and power-state codes
  localparam logic       DIV_PHASE_RST = 1'b0;
  localparam logic [1:0] PWR_RUN       = 2'h0;
  localparam logic [1:0] PWR_IDLE      = 2'h1;
  localparam logic [1:0] PWR_DOWN      = 2'h2;

  typedef enum logic [1:0] {
    OCX_RUN   = 2'b00,
    OCX_IDLE  = 2'b01,
    OCX_DOWN  = 2'b10
  } ocx_pwr_t;

endpackage : ocx_pkg

/* File: rtl/ocx_rst_qual.sv */
`timescale 1ns/1ps
`default_nettype none
// reset pin qualifier: pin synchronised, then counted
module ocx_rst_qual
  import ocx_pkg::*;
#(
  parameter int unsigned QUAL_PERIODS = RST_QUAL_PERIODS
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic rst_pin_i,
  output logic      qual_rst_o
);

  // refused at elaboration: the counter cannot reach larger limits
  if (QUAL_PERIODS < 2 || QUAL_PERIODS >= (1 << RST_CNT_W)) begin : g_bad_qual
    $error("QUAL_PERIODS out of range");
  end

  logic                 sync1_reg;
  logic                 sync2_reg;
  logic [RST_CNT_W-1:0] cnt_reg;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= rst_pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  // short pulses drop the count to zero and never reach the limit
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !sync2_reg) begin
      cnt_reg <= '0;
    end else if (cnt_reg != RST_CNT_W'(QUAL_PERIODS)) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      qual_rst_o <= 1'b0;
    end else begin
      qual_rst_o <= sync2_reg && (cnt_reg >= RST_CNT_W'(QUAL_PERIODS - 1));
    end
  end

  a_short_pulse_ignored: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(qual_rst_o) |-> $past(sync2_reg, 8))
    else $error("reset qualified after short pulse");

endmodule : ocx_rst_qual
`default_nettype wire

/* File: verif/ocx_ext_model.sv */
`timescale 1ns/1ps
`default_nettype none
// reset pin has a pull-down, so it idles low
module ocx_ext_model (
  input  wire logic core_clk_i,
  output logic      rst_pin_o,
  output logic      boot_pin_o
);
  initial begin
    rst_pin_o = 1'b0;
    boot_pin_o = 1'b1;
  end
  // boot level held well past the falling edge of reset
  task automatic press(input int n, input logic bl);
    @(negedge core_clk_i);
    boot_pin_o = bl;
    rst_pin_o = 1'b1;
    repeat (n) @(negedge core_clk_i);
    rst_pin_o = 1'b0;
    repeat (8) @(negedge core_clk_i);
    boot_pin_o = 1'b1;
  endtask : press
endmodule : ocx_ext_model
`default_nettype wire

/* File: verif/tb_osc_clock_x2_reset_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_osc_clock_x2_reset_control;
  import ocx_pkg::*;
  localparam int QP = 8;
  typedef struct packed {logic sel; logic [7:0] cpu; logic [7:0] per;} ocx_row_t;
  logic       core_clk_i, sys_rst_i, rst_pin, boot_pin, fuse, sel, wr, idle, pdown, seen;
  logic       pll_en, cpu_en, per_en, t0, t1, card, adc, spi, port, x2, crst, boot;
  logic [7:0] c, p;
  int         n_mismatch, n_compared, cyc;
  ocx_row_t   rows [4] = '{'{1'b1, 8'h0c, 8'h0c}, '{1'b0, 8'h06, 8'h06},
                           '{1'b1, 8'h0c, 8'h0c}, '{1'b0, 8'h06, 8'h06}};

  ocx_clock_ctrl #(.QUAL_PERIODS(QP)) dut_u (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .rst_pin_i(rst_pin),
    .boot_loader_select_pin_i(boot_pin), .double_speed_default_fuse_i(fuse),
    .double_speed_select_i(sel), .double_speed_wr_i(wr), .idle_req_i(idle), .pdown_req_i(pdown),
    .pll_clk_en_o(pll_en), .cpu_clk_en_o(cpu_en), .per_clk_en_o(per_en), .timer0_clk_en_o(t0),
    .timer1_clk_en_o(t1), .card_clk_en_o(card), .adc_clk_en_o(adc), .spi_clk_en_o(spi),
    .port_smp_clk_en_o(port), .double_speed_o(x2), .core_rst_o(crst), .boot_loader_o(boot));
  ocx_ext_model ext_u (.core_clk_i(core_clk_i), .rst_pin_o(rst_pin), .boot_pin_o(boot_pin));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // sticky: a one-cycle reset pulse would be missed by end-of-test sampling
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (crst === 1'b1) seen <= 1'b1;
    if (cyc == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : check

  // enables lag the speed flag by one edge, so the runt test uses the earlier flag
  task automatic measure();
    logic pc;
    logic px;
    c = 8'h00;
    p = 8'h00;
    pc = 1'b0;
    px = x2;
    repeat (12) begin
      @(negedge core_clk_i);
      c = c + 8'(cpu_en);
      p = p + 8'(per_en);
      check({t0, t1, card, adc, spi, port} === {6{per_en}}, "fanout");
      check(!(pc && cpu_en && !px), "runt");
      pc = cpu_en;
      px = x2;
    end
  endtask : measure

  task automatic write_speed(input logic v);
    sel = v;
    wr = 1'b1;
    @(negedge core_clk_i);
    wr = 1'b0;
  endtask : write_speed

  initial begin
    sys_rst_i = 1'b1;
    fuse = 1'b0;
    sel = 1'b0;
    wr = 1'b0;
    idle = 1'b0;
    pdown = 1'b0;
    seen = 1'b0;
    repeat (16) @(negedge core_clk_i);
    check(crst === 1'b1, "reset held");
    sys_rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check({crst, x2, boot, pll_en} === 4'b0001, "after reset");
    measure();
    check({c, p} === {8'h06, 8'h06}, "standard rate");
    foreach (rows[i]) begin
      write_speed(rows[i].sel);
      repeat (4) @(negedge core_clk_i);
      measure();
      check({x2, c, p} === {rows[i].sel, rows[i].cpu, rows[i].per}, "mode rate");
    end
    // back-to-back writes: strobe held, data changed, the later one must win
    sel = 1'b1;
    wr = 1'b1;
    @(negedge core_clk_i);
    sel = 1'b0;
    @(negedge core_clk_i);
    wr = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check(x2 === 1'b0, "last write");
    write_speed(1'b1);
    measure();
    write_speed(1'b0);
    measure();
    idle = 1'b1;
    @(negedge core_clk_i);
    idle = 1'b0;
    measure();
    check({c, p} === {8'h00, 8'h06}, "idle gating");
    pdown = 1'b1;
    @(negedge core_clk_i);
    pdown = 1'b0;
    measure();
    check({pll_en, c, p} === 17'h0_0000, "power-down gating");
    seen = 1'b0;
    ext_u.press(QP - 2, 1'b1);
    check({seen, pll_en} === 2'b00, "short pulse");
    fuse = 1'b1;
    ext_u.press(QP + 6, 1'b0);
    repeat (4) @(negedge core_clk_i);
    check({seen, crst, boot, x2, pll_en} === 5'b10111, "pin wake");
    measure();
    check(c === 8'h0c, "fuse speed");
    report_and_stop();
  end
endmodule : tb_osc_clock_x2_reset_control
`default_nettype wire
